// [arnm_pkg.sv]
// Notes on behaviour
// [R1] opcode 29h reads sectors to host
// [R2] payload moves as 16-bit data words
// [R3] one interrupt per multiple-block, not sector
// [R4] count low byte current, high byte previous
// [R5] zero sector count means 65,536 sectors
// [R6] start LBA from current and previous bytes
// [R7] failing LBA readable, HOB selects upper half
// [R8] UNC/IDNF/ABRT/AMNF errors, ERR set, BSY clear
// [R9] opcode F8h returns unreduced native maximum
// [R10] native max above 268,435,455 saturates
// [R11] LBA result bytes into SN, CL, CH, head
// [R12] CHS result returns highest head number
// [R13] L bit selects LBA or CHS format
package arnm_pkg;
   localparam logic [7:0] CMD_RD_MULT_EXT = 8'h29;
   localparam logic [7:0] CMD_NATIVE_MAX = 8'hF8;
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_ERROR = 8'h04;
   localparam logic [7:0] OFS_SECCNT = 8'h08;
   localparam logic [7:0] OFS_CYLHI = 8'h14;
   localparam logic [7:0] OFS_DEVHEAD = 8'h18;
   localparam logic [7:0] OFS_CMDSTAT = 8'h1C;
   localparam logic [7:0] OFS_DEVCTL = 8'h20;
   localparam logic [7:0] OFS_INT_STAT = 8'h24;
   localparam logic [7:0] OFS_INT_MASK = 8'h28;
   localparam logic [7:0] OFS_MULT = 8'h2C;
   localparam logic [1:0] TF_CNT = 2'h0;
   localparam logic [1:0] TF_SN = 2'h1;
   localparam logic [1:0] TF_CL = 2'h2;
   localparam logic [1:0] TF_CH = 2'h3;
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_UNC = 6;
   localparam int ER_IDN = 4;
   localparam int ER_ABT = 2;
   localparam int ER_AMN = 0;
   localparam int DH_L = 6;
   localparam int DC_HOB = 7;
   localparam int INT_W = 3;
   localparam int INT_BLOCK = 0;
   localparam int INT_DONE = 1;
   localparam int INT_ERR = 2;
   localparam logic [7:0] LAST_WORD = 8'hFF;
   localparam logic [7:0] ONE_BLOCK = 8'h01;
   localparam logic [16:0] ZERO_CNT_SECTORS = 17'h10000;
   localparam logic [27:0] SAT_LBA28 = 28'hFFFFFFF;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      MERR_NONE = 2'b00,
      MERR_UNC = 2'b01,
      MERR_IDNF = 2'b10,
      MERR_AMNF = 2'b11
   } arnm_merr_type;
   typedef struct packed {
      logic valid;
      arnm_merr_type err;
      logic [15:0] word;
   } arnm_media_type;
   typedef struct packed {
      logic [47:0] lba;
      logic [15:0] cyl;
      logic [3:0] head;
      logic [7:0] sect;
   } arnm_geom_type;
   typedef struct packed {
      logic wr;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic rd;
      logic [7:0] raddr;
   } arnm_req_type;
   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] cur;
   } arnm_pair_type;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic is_tf(input logic [7:0] a);
      return (a >= OFS_SECCNT) && (a <= OFS_CYLHI) && (a[1:0] == 2'h0);
   endfunction
   function automatic logic [1:0] tf_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - OFS_SECCNT;
      return d[3:2];
   endfunction
   function automatic logic is_mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= OFS_MULT);
   endfunction
endpackage

// [arnm_axil_slave.sv]
`timescale 1ns/1ps
module arnm_axil_slave (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output arnm_pkg::arnm_req_type req,
   input wire logic [31:0] rd_data,
   input wire logic hit_wr,
   input wire logic hit_rd
);
   import arnm_pkg::*;
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_got;
      logic [7:0] raddr;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } arnm_bus_st_type;
   arnm_bus_st_type s_ff, nxt_s;
   // write and read each hold off new addresses until their response is accepted
   assign awready = ~s_ff.aw_got & ~s_ff.bvalid;
   assign wready = ~s_ff.w_got & ~s_ff.bvalid;
   assign arready = ~s_ff.ar_got & ~s_ff.rvalid;
   assign bvalid = s_ff.bvalid;
   assign bresp = s_ff.bresp;
   assign rvalid = s_ff.rvalid;
   assign rdata = s_ff.rdata;
   assign rresp = s_ff.rresp;
   assign req = '{wr: s_ff.aw_got & s_ff.w_got, waddr: s_ff.waddr, wdata: s_ff.wdata,
                  wstrb: s_ff.wstrb, rd: s_ff.ar_got, raddr: s_ff.raddr};
   always_comb begin
      nxt_s = s_ff;
      if (awvalid & awready) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.waddr = awaddr;
      end
      if (wvalid & wready) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdata = wdata;
         nxt_s.wstrb = wstrb;
      end
      if (s_ff.aw_got & s_ff.w_got) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = hit_wr ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_ff.bvalid & bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (arvalid & arready) begin
         nxt_s.ar_got = 1'b1;
         nxt_s.raddr = araddr;
      end
      if (s_ff.ar_got) begin
         nxt_s.ar_got = 1'b0;
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = hit_rd ? rd_data : '0;
         nxt_s.rresp = hit_rd ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_ff.rvalid & rready) begin
         nxt_s.rvalid = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule // arnm_axil_slave

// [arnm_native_fmt.sv]
`timescale 1ns/1ps
module arnm_native_fmt (
   input arnm_pkg::arnm_geom_type geom,
   input wire logic lmode,
   output logic [7:0] sn,
   output logic [7:0] cl,
   output logic [7:0] ch,
   output logic [3:0] head
);
   import arnm_pkg::*;
   logic [27:0] lba28;
   always_comb begin
      // any bit above the 28-bit range pins the answer at the ceiling
      lba28 = (|geom.lba[47:28]) ? SAT_LBA28 : geom.lba[27:0]; // [R10]
      if (lmode) begin // [R13]
         sn = lba28[7:0]; // [R11]
         cl = lba28[15:8];
         ch = lba28[23:16];
         head = lba28[27:24];
      end else begin
         sn = geom.sect;
         cl = geom.cyl[7:0];
         ch = geom.cyl[15:8];
         head = geom.head; // [R12]
      end
   end
endmodule // arnm_native_fmt

// [arnm_top.sv]
`timescale 1ns/1ps
module arnm_top (
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic MEDIA_REQ,
   output logic [47:0] MEDIA_LBA,
   input arnm_pkg::arnm_media_type MEDIA_IN,
   input arnm_pkg::arnm_geom_type NATIVE_GEOM,
   output logic IRQ
);
   import arnm_pkg::*;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_FETCH = 2'b01,
      S_XFER = 2'b10
   } arnm_fsm_type;
   typedef struct packed {
      arnm_pair_type [3:0] tf;
      logic [7:0] devhead;
      logic [7:0] err;
      logic [7:0] devctl;
      logic [7:0] mult;
      logic [INT_W-1:0] int_st;
      logic [INT_W-1:0] int_mask;
      arnm_fsm_type fsm;
      logic bsy;
      logic drq;
      logic errs;
      logic [47:0] lba;
      logic [16:0] left;
      logic [7:0] blk_left;
      logic blk_first;
      logic [7:0] word_cnt;
      logic [15:0] word;
   } arnm_top_st_type;
   arnm_top_st_type s_ff, nxt_s;
   arnm_req_type req;
   logic [31:0] rd_data;
   logic hit_wr, hit_rd, wr_ok, cmd_go, pop, take;
   logic [7:0] status, mult_eff, nm_sn, nm_cl, nm_ch;
   logic [3:0] nm_head;
   logic [15:0] cnt16;
   logic [47:0] start_lba;
   logic [INT_W-1:0] ev;
   ////////////////////////////////////////////////////////////////////////////////
   arnm_axil_slave u_bus (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .awaddr(S_AXI_AWADDR),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .bresp(S_AXI_BRESP),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .araddr(S_AXI_ARADDR),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .req(req),
      .rd_data(rd_data),
      .hit_wr(hit_wr),
      .hit_rd(hit_rd)
   );
   arnm_native_fmt u_fmt (
      .geom(NATIVE_GEOM),
      .lmode(s_ff.devhead[DH_L]),
      .sn(nm_sn),
      .cl(nm_cl),
      .ch(nm_ch),
      .head(nm_head)
   );
   assign MEDIA_REQ = (s_ff.fsm == S_FETCH);
   assign MEDIA_LBA = s_ff.lba;
   assign IRQ = |(s_ff.int_st & s_ff.int_mask);
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin : read_side
      hit_wr = is_mapped(req.waddr);
      hit_rd = is_mapped(req.raddr);
      status = '0;
      status[ST_BSY] = s_ff.bsy;
      status[ST_RDY] = ~s_ff.bsy;
      status[ST_DSC] = ~s_ff.bsy;
      status[ST_DRQ] = s_ff.drq;
      status[ST_ERR] = s_ff.errs; // [R8]
      rd_data = '0;
      case (req.raddr)
         OFS_DATA: rd_data[15:0] = s_ff.word; // [R2]
         OFS_ERROR: rd_data[7:0] = s_ff.err;
         OFS_DEVHEAD: rd_data[7:0] = s_ff.devhead;
         OFS_CMDSTAT: rd_data[7:0] = status;
         OFS_DEVCTL: rd_data[7:0] = s_ff.devctl;
         OFS_INT_STAT: rd_data[INT_W-1:0] = s_ff.int_st;
         OFS_INT_MASK: rd_data[INT_W-1:0] = s_ff.int_mask;
         OFS_MULT: rd_data[7:0] = s_ff.mult;
         default: begin
            if (is_tf(req.raddr)) begin // [R7]
               rd_data[7:0] = s_ff.devctl[DC_HOB] ? s_ff.tf[tf_index(req.raddr)].prev
                                                   : s_ff.tf[tf_index(req.raddr)].cur;
            end
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin : next_state
      nxt_s = s_ff;
      ev = '0;
      // taskfile writes while busy or mid-transfer would corrupt the command in flight
      wr_ok = req.wr & req.wstrb[0] & (s_ff.fsm == S_IDLE);
      cmd_go = wr_ok & (req.waddr == OFS_CMDSTAT);
      pop = req.rd & (req.raddr == OFS_DATA) & s_ff.drq;
      take = (s_ff.fsm == S_FETCH) & MEDIA_IN.valid;
      cnt16 = {s_ff.tf[TF_CNT].prev, s_ff.tf[TF_CNT].cur}; // [R4]
      start_lba = {s_ff.tf[TF_CH].prev, s_ff.tf[TF_CL].prev, s_ff.tf[TF_SN].prev,
                   s_ff.tf[TF_CH].cur, s_ff.tf[TF_CL].cur, s_ff.tf[TF_SN].cur}; // [R6]
      mult_eff = (s_ff.mult == RST_BYTE) ? ONE_BLOCK : s_ff.mult;
      if (wr_ok) begin
         if (is_tf(req.waddr)) begin // [R4]
            nxt_s.tf[tf_index(req.waddr)].prev = s_ff.tf[tf_index(req.waddr)].cur;
            nxt_s.tf[tf_index(req.waddr)].cur = req.wdata[7:0];
         end
         case (req.waddr)
            OFS_DEVHEAD: nxt_s.devhead = req.wdata[7:0];
            OFS_DEVCTL: nxt_s.devctl = req.wdata[7:0];
            OFS_MULT: nxt_s.mult = req.wdata[7:0];
            default: ;
         endcase
      end
      if (cmd_go) begin
         nxt_s.err = '0;
         nxt_s.errs = 1'b0;
         case (req.wdata[7:0])
            CMD_RD_MULT_EXT: begin // [R1]
               nxt_s.lba = start_lba;
               nxt_s.left = (cnt16 == 16'h0000) ? ZERO_CNT_SECTORS : {1'b0, cnt16}; // [R5]
               nxt_s.blk_left = mult_eff;
               nxt_s.blk_first = 1'b1;
               nxt_s.word_cnt = '0;
               nxt_s.bsy = 1'b1;
               nxt_s.fsm = S_FETCH;
            end
            CMD_NATIVE_MAX: begin // [R9]
               nxt_s.tf[TF_SN].cur = nm_sn; // [R11]
               nxt_s.tf[TF_CL].cur = nm_cl;
               nxt_s.tf[TF_CH].cur = nm_ch;
               nxt_s.devhead[3:0] = nm_head; // [R12]
               ev[INT_DONE] = 1'b1;
            end
            default: begin
               nxt_s.err[ER_ABT] = 1'b1; // [R8]
               nxt_s.errs = 1'b1;
               ev[INT_ERR] = 1'b1;
            end
         endcase
      end
      if (take) begin
         if (MEDIA_IN.err != MERR_NONE) begin
            nxt_s.err[ER_UNC] = (MEDIA_IN.err == MERR_UNC); // [R8]
            nxt_s.err[ER_IDN] = (MEDIA_IN.err == MERR_IDNF);
            nxt_s.err[ER_AMN] = (MEDIA_IN.err == MERR_AMNF);
            nxt_s.errs = 1'b1;
            nxt_s.bsy = 1'b0;
            nxt_s.fsm = S_IDLE;
            nxt_s.tf[TF_CNT] = '{prev: s_ff.left[15:8], cur: s_ff.left[7:0]};
            nxt_s.tf[TF_SN] = '{prev: s_ff.lba[31:24], cur: s_ff.lba[7:0]}; // [R7]
            nxt_s.tf[TF_CL] = '{prev: s_ff.lba[39:32], cur: s_ff.lba[15:8]};
            nxt_s.tf[TF_CH] = '{prev: s_ff.lba[47:40], cur: s_ff.lba[23:16]};
            ev[INT_ERR] = 1'b1;
         end else begin
            nxt_s.word = MEDIA_IN.word; // [R2]
            nxt_s.drq = 1'b1;
            nxt_s.bsy = 1'b0;
            nxt_s.blk_first = 1'b0;
            nxt_s.fsm = S_XFER;
            ev[INT_BLOCK] = s_ff.blk_first; // [R3]
         end
      end
      if (pop) begin
         nxt_s.drq = 1'b0;
         nxt_s.fsm = S_FETCH;
         nxt_s.word_cnt = s_ff.word_cnt + 8'h01;
         if (s_ff.word_cnt == LAST_WORD) begin
            nxt_s.lba = s_ff.lba + 48'h000000000001;
            nxt_s.left = s_ff.left - 17'h00001;
            nxt_s.blk_left = s_ff.blk_left - 8'h01;
            nxt_s.bsy = 1'b1;
            if (s_ff.left == 17'h00001) begin
               nxt_s.fsm = S_IDLE;
               nxt_s.bsy = 1'b0;
               nxt_s.tf[TF_CNT] = '{prev: RST_BYTE, cur: RST_BYTE};
               ev[INT_DONE] = 1'b1;
            end else if (s_ff.blk_left == ONE_BLOCK) begin // [R3]
               nxt_s.blk_left = mult_eff;
               nxt_s.blk_first = 1'b1;
            end
         end
      end
      // a new event wins over a clear in the same cycle
      if (req.wr & req.wstrb[0] & (req.waddr == OFS_INT_STAT)) begin
         nxt_s.int_st = s_ff.int_st & ~req.wdata[INT_W-1:0];
      end
      if (req.wr & req.wstrb[0] & (req.waddr == OFS_INT_MASK)) begin
         nxt_s.int_mask = req.wdata[INT_W-1:0];
      end
      nxt_s.int_st = nxt_s.int_st | ev;
   end
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   a_cmd_starts_fetch: assert property (cmd_go && req.wdata[7:0] == CMD_RD_MULT_EXT |=> // [R1]
      s_ff.fsm == S_FETCH && s_ff.bsy && MEDIA_REQ) else $error("read command did not start fetch");
   a_drq_holds_word: assert property (take && MEDIA_IN.err == MERR_NONE |=> // [R2]
      s_ff.drq && s_ff.word == $past(MEDIA_IN.word)) else $error("media word not presented");
   a_block_irq_once: assert property (take && MEDIA_IN.err == MERR_NONE && !s_ff.blk_first |=> // [R3]
      $stable(s_ff.int_st[INT_BLOCK]) || $past(req.wr)) else $error("block event raised mid block");
   a_count_zero: assert property (cmd_go && req.wdata[7:0] == CMD_RD_MULT_EXT && cnt16 == 16'h0000 |=> // [R5]
      s_ff.left == ZERO_CNT_SECTORS) else $error("zero count not 65536");
   a_start_lba: assert property (cmd_go && req.wdata[7:0] == CMD_RD_MULT_EXT |=> // [R6]
      MEDIA_LBA == $past(start_lba)) else $error("start address assembled wrong");
   a_fail_lba: assert property (take && MEDIA_IN.err != MERR_NONE |=> // [R7]
      s_ff.tf[TF_SN].cur == $past(s_ff.lba[7:0]) && s_ff.tf[TF_CH].prev == $past(s_ff.lba[47:40]))
      else $error("failing address not reported");
   a_err_ends_cmd: assert property (take && MEDIA_IN.err != MERR_NONE |=> // [R8]
      status[ST_ERR] && !status[ST_BSY] && !s_ff.drq ##1 s_ff.fsm == S_IDLE) else $error("error not reported");
   a_native_sat: assert property (cmd_go && req.wdata[7:0] == CMD_NATIVE_MAX && s_ff.devhead[DH_L] // [R10]
      && |NATIVE_GEOM.lba[47:28] |=> {s_ff.devhead[3:0], s_ff.tf[TF_CH].cur, s_ff.tf[TF_CL].cur,
      s_ff.tf[TF_SN].cur} == SAT_LBA28) else $error("native max not saturated");
   a_chs_head: assert property (cmd_go && req.wdata[7:0] == CMD_NATIVE_MAX && !s_ff.devhead[DH_L] |=> // [R12]
      s_ff.devhead[3:0] == $past(NATIVE_GEOM.head) && !s_ff.bsy) else $error("chs head wrong");
   c_read_multi: cover property (cmd_go && req.wdata[7:0] == CMD_RD_MULT_EXT);
   c_native_max: cover property (cmd_go && req.wdata[7:0] == CMD_NATIVE_MAX);
   c_media_error: cover property (take && MEDIA_IN.err != MERR_NONE);
   c_block_turn: cover property (pop && s_ff.word_cnt == LAST_WORD && s_ff.blk_left == ONE_BLOCK);
endmodule // arnm_top

// [arnm_media_model.sv]
`timescale 1ns/1ps
module arnm_media_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic req,
   input wire logic [47:0] lba,
   input wire logic slow,
   input wire logic restart,
   input arnm_pkg::arnm_merr_type fail,
   output arnm_pkg::arnm_media_type media
);
   import arnm_pkg::*;
   typedef struct packed {
      logic [7:0] idx;
      logic tgl;
      logic [15:0] last;
   } arnm_mdl_type;
   arnm_mdl_type st_ff;
   arnm_mdl_type nxt_st;
   logic give;
   ////////////////////////////////////////////////////////////////////////////////
   // slow mode offers a word only every other cycle, so the device must wait
   assign give = req && (!slow || st_ff.tgl);
   always_comb begin
      media.valid = give;
      media.err = give ? fail : MERR_NONE;
      // a stalled line shows the inverse of the last word, never a stale copy
      media.word = give ? {lba[7:0], st_ff.idx} : ~st_ff.last;
      nxt_st = st_ff;
      nxt_st.tgl = ~st_ff.tgl;
      if (give) begin
         nxt_st.idx = st_ff.idx + 8'h01;
         nxt_st.last = media.word;
      end
      if (restart) begin
         nxt_st.idx = 8'h00;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // arnm_media_model

// [arnm_tb_top.sv]
`timescale 1ns/1ps
module arnm_tb_top;
   import arnm_pkg::*;
   logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic mreq, irq, slow, restart;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdat;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, lresp;
   logic [47:0] mlba;
   arnm_media_type media;
   arnm_geom_type geom;
   arnm_merr_type fail;
   int n_mismatch, n_compared, nblk;
   localparam logic [47:0] RLBA = 48'h030201302010;
   localparam logic [47:0] ELBA = 48'hA5A4A3A2A1A0;
   logic [7:0] row_a [6] = '{OFS_SECCNT, OFS_DEVHEAD, OFS_MULT, OFS_INT_MASK, 8'h30, 8'h09};
   logic [7:0] row_w [6] = '{8'h5A, 8'h4F, 8'h02, 8'h07, 8'h77, 8'h77};
   logic [7:0] row_x [6] = '{8'h5A, 8'h4F, 8'h02, 8'h07, 8'h00, 8'h00};
   logic [1:0] row_r [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_SLVERR};
   logic f_l [3] = '{1'b1, 1'b1, 1'b0};
   arnm_geom_type f_g [3] = '{'{48'h0ABCDEF1, 16'h0, 4'h0, 8'h0}, '{48'h10000000, 16'h0, 4'h0, 8'h0},
      '{48'h5, 16'h1357, 4'h9, 8'h3F}};
   logic [27:0] f_x [3] = '{28'hABCDEF1, 28'hFFFFFFF, 28'h913573F};
   arnm_merr_type e_c [3] = '{MERR_UNC, MERR_IDNF, MERR_AMNF};
   logic [7:0] e_x [3] = '{8'h40, 8'h10, 8'h01};
   logic [15:0] e_n [3] = '{16'h0000, 16'h0100, 16'h0005};
   ////////////////////////////////////////////////////////////////////////////////
   arnm_top arnm_top_i (.REF_CLK(clk), .ARST_N(arst_n), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .MEDIA_REQ(mreq),
      .MEDIA_LBA(mlba), .MEDIA_IN(media), .NATIVE_GEOM(geom), .IRQ(irq));
   arnm_media_model arnm_media_model_i (.clk(clk), .arst_n(arst_n), .req(mreq), .lba(mlba), .slow(slow),
      .restart(restart), .fail(fail), .media(media));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic [1:0] g, input logic [1:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // ready is sampled mid-cycle: it only moves at rising edges, so no race
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta, tw, bv;
      int n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bv = 1'b0;
      while (!bv && n < 100) begin
         @(negedge clk);
         ta = awready;
         tw = wready;
         bv = bvalid;
         lresp = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      chk(bv, 1'b1);
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, rv;
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rv = 1'b0;
      while (!rv && n < 100) begin
         @(negedge clk);
         ta = arready;
         rv = rvalid;
         rdat = rdata;
         lresp = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         n++;
      end
      chk(rv, 1'b1);
   endtask
   // irq is looked at mid-cycle, clear of the edge that launches it
   task automatic irqc(input logic e);
      @(negedge clk);
      chk(irq, e);
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rdat, e);
   endtask
   task automatic wst(input int b, input logic v);
      int n = 0;
      rd(OFS_CMDSTAT);
      while (rdat[b] !== v && n < 300) begin
         rd(OFS_CMDSTAT);
         n++;
      end
      chk(rdat[b], v);
   endtask
   // count goes previous byte first: each write shifts current into previous
   task automatic tf(input logic [15:0] c, input logic [47:0] l);
      logic [7:0] hb, lb;
      for (int i = 0; i < 4; i++) begin
         hb = (i == 0) ? c[15:8] : l[16 + 8 * i +: 8];
         lb = (i == 0) ? c[7:0] : l[8 * i - 8 +: 8];
         wr(OFS_SECCNT + 8'(4 * i), hb);
         wr(OFS_SECCNT + 8'(4 * i), lb);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      test_done;
   end
   initial begin
      {arst_n, awvalid, wvalid, arvalid, slow, restart, nblk} = '0;
      {awaddr, araddr, wdata, geom} = '0;
      fail = MERR_NONE;
      wstrb = 4'hF;
      bready = 1'b1;
      rready = 1'b1;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdc(OFS_CMDSTAT, 32'h50);
      rdc(OFS_INT_STAT, 32'h0);
      chk(irq, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wr(row_a[i], row_w[i]);
         chkb(lresp, row_r[i]);
         rd(row_a[i]);
         chkb(lresp, row_r[i]);
         chk(rdat, row_x[i]);
      end
      for (int i = 0; i < 3; i++) begin
         geom <= f_g[i];
         wr(OFS_DEVHEAD, f_l[i] ? 8'hE0 : 8'hA0);
         wr(OFS_CMDSTAT, CMD_NATIVE_MAX);
         wst(ST_BSY, 1'b0);
         for (int j = 0; j < 3; j++) rdc(OFS_SECCNT + 8'(4 * j + 4), f_x[i][8 * j +: 8]);
         rd(OFS_DEVHEAD);
         chk(rdat[3:0], f_x[i][27:24]);
         rd(OFS_INT_STAT);
         chk(rdat[INT_DONE], 1'b1);
         wr(OFS_INT_STAT, 8'h07);
      end
      slow <= 1'b1;
      tf(16'h0003, RLBA);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      wr(OFS_CMDSTAT, CMD_RD_MULT_EXT);
      for (int s = 0; s < 3; s++) for (int w = 0; w < 256; w++) begin
         wst(ST_DRQ, 1'b1);
         if (w == 0) chk(mlba, RLBA + 48'(s));
         rdc(OFS_DATA, {16'h0, 8'h10 + 8'(s), 8'(w)});
         rd(OFS_INT_STAT);
         if (rdat[INT_BLOCK] === 1'b1) begin
            nblk++;
            wr(OFS_INT_STAT, 8'h01);
         end
      end
      wst(ST_BSY, 1'b0);
      rd(OFS_INT_STAT);
      if (rdat[INT_BLOCK] === 1'b1) nblk++;
      chk(nblk, 2);
      chk(rdat[INT_DONE], 1'b1);
      rdc(OFS_CMDSTAT, 32'h50);
      rdc(OFS_SECCNT, 32'h0);
      irqc(1'b1);
      wr(OFS_INT_MASK, 8'h00);
      irqc(1'b0);
      wr(OFS_INT_MASK, 8'h07);
      wr(OFS_INT_STAT, 8'h07);
      irqc(1'b0);
      slow <= 1'b0;
      // each media fault aborts on the first word, so every byte of the start address is reported
      for (int i = 0; i < 3; i++) begin
         fail <= e_c[i];
         tf(e_n[i], ELBA);
         wr(OFS_CMDSTAT, CMD_RD_MULT_EXT);
         wst(ST_BSY, 1'b0);
         rdc(OFS_ERROR, e_x[i]);
         rdc(OFS_CMDSTAT, 32'h51);
         for (int h = 0; h < 2; h++) begin
            wr(OFS_DEVCTL, h ? 8'h80 : 8'h00);
            rdc(OFS_SECCNT, e_n[i][8 * h +: 8]);
            for (int j = 0; j < 3; j++) rdc(OFS_SECCNT + 8'(4 * j + 4), ELBA[24 * h + 8 * j +: 8]);
         end
         wr(OFS_DEVCTL, 8'h00);
         rd(OFS_INT_STAT);
         chk(rdat[INT_ERR], 1'b1);
         wr(OFS_INT_STAT, 8'h07);
      end
      fail <= MERR_NONE;
      wr(OFS_CMDSTAT, 8'hC4);
      wst(ST_BSY, 1'b0);
      rdc(OFS_ERROR, 32'h04);
      rdc(OFS_CMDSTAT, 32'h51);
      // mid-run reset: error, mask and the pending interrupt must all clear
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdc(OFS_ERROR, 32'h0);
      rdc(OFS_CMDSTAT, 32'h50);
      rdc(OFS_INT_MASK, 32'h0);
      irqc(1'b0);
      test_done;
   end
endmodule // arnm_tb_top
